// File: rtl/ofr_params.svh
`ifndef OFR_PARAMS_SVH
`define OFR_PARAMS_SVH

// Register byte addresses inside the slave's 256-byte window
`define OFR_ADDR_CTRL_SEL 8'h00
`define OFR_ADDR_AUX_SEL 8'h04
`define OFR_ADDR_MASK 8'h08
`define OFR_ADDR_CONFIG 8'h0c
`define OFR_ADDR_STATUS 8'h10

// Selector field layout: one 5-bit field per byte lane
`define OFR_SEL_W 5
`define OFR_SEL_STRIDE 8

// Configuration register fields
`define OFR_CFG_HEAT_COOL 0
`define OFR_CFG_PATTERN_ON 1
`define OFR_CFG_SOAK_LSB 2
`define OFR_CFG_ALARM_TARGET 4

// Soak time unit codes
`define OFR_SOAK_SEC 2'h0
`define OFR_SOAK_MIN 2'h1
`define OFR_SOAK_HOUR 2'h2

// Reset values
`define OFR_RST_MASK 8'h31
`define OFR_RST_SOAK `OFR_SOAK_MIN

`endif

// File: rtl/ofr_pkg.sv
package ofr_pkg;

  // Output source selections, in register code order starting at zero
  typedef enum logic [4:0] {
    SRC_NONE, SRC_HEAT, SRC_COOL, SRC_AL1, SRC_AL2, SRC_AL3, SRC_AL4,
    SRC_HEATER, SRC_BURNOUT, SRC_SHORT, SRC_INERR, SRC_OFF2, SRC_PEND,
    SRC_RUN, SRC_COMB, SRC_WF1, SRC_WF2, SRC_WF3, SRC_WF4, SRC_WF5,
    SRC_WF6, SRC_WF7, SRC_WF8
  } ofr_src_e;

  // Internal function states that an output may carry
  typedef struct packed {
    logic heat_mv;
    logic cool_mv;
    logic [3:0] alarm;
    logic heater_alarm;
    logic heater_burnout_alarm;
    logic heater_short_alarm;
    logic input_error;
    logic program_end;
    logic run_state;
    logic [7:0] logic_work_flag;
  } ofr_func_s;

  // Fitted hardware of this unit, from straps
  typedef struct packed {
    logic two_ctrl_outputs;
    logic [1:0] ctrl_switching;
    logic [3:0] aux_present;
    logic aux_two_only;
    logic heater_detect;
    logic logic_op_used;
  } ofr_variant_s;

endpackage

// File: rtl/ofr_sync.sv
`timescale 1ns/100ps
`default_nettype none
module ofr_sync #(
  parameter int W = 10
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta;

  // Two stages; only the second stage reads the first
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      meta <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule
`default_nettype wire

// File: rtl/ofr_source_mux.sv
`timescale 1ns/100ps
`default_nettype none
module ofr_source_mux
  import ofr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire ofr_src_e sel,
  input wire ofr_func_s funcs,
  input wire logic combined,
  input wire logic heat_cool,
  input wire logic pattern_on,
  input wire logic present,
  output logic drive
);
  logic next_drive;

  // Source selection; an absent terminal stays off
  always_comb
  begin
    next_drive = 1'b0;
    case (sel)
      SRC_NONE: next_drive = 1'b0;
      SRC_OFF2: next_drive = 1'b0;
      SRC_HEAT: next_drive = funcs.heat_mv;
      SRC_COOL: next_drive = funcs.cool_mv & heat_cool;
      SRC_AL1: next_drive = funcs.alarm[0];
      SRC_AL2: next_drive = funcs.alarm[1];
      SRC_AL3: next_drive = funcs.alarm[2];
      SRC_AL4: next_drive = funcs.alarm[3];
      SRC_HEATER: next_drive = funcs.heater_alarm;
      SRC_BURNOUT: next_drive = funcs.heater_burnout_alarm;
      SRC_SHORT: next_drive = funcs.heater_short_alarm;
      SRC_INERR: next_drive = funcs.input_error;
      SRC_PEND: next_drive = funcs.program_end & pattern_on;
      SRC_RUN: next_drive = funcs.run_state;
      SRC_COMB: next_drive = combined;
      default:
      begin
        if (sel >= SRC_WF1 && sel <= SRC_WF8)
          next_drive = funcs.logic_work_flag[3'(sel - SRC_WF1)];
        else
          next_drive = 1'b0;
      end
    endcase
  end

  // Registered drive, one cycle behind its source
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      drive <= 1'b0;
    else
      drive <= next_drive & present;
  end
endmodule
`default_nettype wire

// File: rtl/ofr_router.sv
// The register addresses and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "ofr_params.svh"
module ofr_router
  import ofr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire ofr_func_s funcs,
  input wire ofr_variant_s variant_pins,
  output logic [1:0] ctrl_out,
  output logic [3:0] aux_out,
  output logic combined_alarm,
  output logic [1:0] soak_time_unit,
  output logic soak_unit_valid,
  output logic alarm_ref_target
);
  ofr_variant_s variant;
  logic [$bits(ofr_variant_s)-1:0] variant_raw;
  logic dp_valid;
  logic dp_write;
  logic [7:0] dp_addr;
  logic wr_ctrl;
  logic wr_aux;
  logic wr_mask;
  logic wr_cfg;
  logic init_pending;
  ofr_src_e out_sel [0:5];
  logic [7:0] combined_alarm_source_mask;
  logic heat_cool;
  logic pattern_on;
  logic [1:0] soak_unit;
  logic alarm_target;
  logic [5:0] out_drive;
  logic [5:0] out_present;
  logic combined_now;
  logic hc_rise;
  logic [1:0] new_soak;
  logic [31:0] next_rdata;

  // Straps come from pins, so they cross two flops before use
  ofr_sync #(
    .W($bits(ofr_variant_s))
  ) u_variant_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_in(variant_pins),
    .sync_out(variant_raw)
  );
  assign variant = ofr_variant_s'(variant_raw);

  // Zero wait states and never an error, so the slave needs no stall logic
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Address phase capture; upper address bits are not decoded
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr <= 8'h00;
    end
    else if (hready)
    begin
      dp_valid <= hsel & htrans[1];
      dp_write <= hwrite;
      dp_addr <= haddr[7:0];
    end
  end

  // Data phase write strobes
  assign wr_ctrl = dp_valid & dp_write & (dp_addr == `OFR_ADDR_CTRL_SEL);
  assign wr_aux = dp_valid & dp_write & (dp_addr == `OFR_ADDR_AUX_SEL);
  assign wr_mask = dp_valid & dp_write & (dp_addr == `OFR_ADDR_MASK);
  assign wr_cfg = dp_valid & dp_write & (dp_addr == `OFR_ADDR_CONFIG);

  // Only a switch from standard into heating/cooling triggers rerouting
  assign hc_rise = wr_cfg & hwdata[`OFR_CFG_HEAT_COOL] & ~heat_cool;
  assign new_soak = hwdata[`OFR_CFG_SOAK_LSB +: 2];

  // Refused selections leave the field unchanged rather than erroring the bus
  function automatic logic sel_ok(
    input logic [4:0] code,
    input logic is_ctrl,
    input logic switching,
    input logic logic_used
  );
    logic ok;
    ok = (code <= 5'(SRC_WF8));
    if (code >= 5'(SRC_WF1) && !logic_used)
      ok = 1'b0;
    if (is_ctrl && code >= 5'(SRC_AL1) && !switching)
      ok = 1'b0;
    return ok;
  endfunction

  // First three cycles after reset: straps are not settled in the sync until cycle 2,
  // so the heater default waits for the flag to clear at the third edge
  logic [1:0] init_cnt;
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      init_cnt <= 2'h0;
      init_pending <= 1'b1;
    end
    else
    begin
      if (init_cnt != 2'h2)
        init_cnt <= init_cnt + 2'h1;
      init_pending <= (init_cnt != 2'h2);
    end
  end

  // Output source selectors
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      out_sel[0] <= SRC_HEAT;
      out_sel[1] <= SRC_NONE;
      out_sel[2] <= SRC_AL1;
      out_sel[3] <= SRC_AL2;
      out_sel[4] <= SRC_AL3;
      out_sel[5] <= SRC_AL4;
    end
    else
    begin
      if (init_pending && init_cnt == 2'h2 && variant.heater_detect && out_sel[2] == SRC_AL1)
        out_sel[2] <= SRC_HEATER;
      if (wr_ctrl)
      begin
        for (int i = 0; i < 2; i++)
        begin
          if (sel_ok(hwdata[i*`OFR_SEL_STRIDE +: `OFR_SEL_W], 1'b1, variant.ctrl_switching[i],
                     variant.logic_op_used))
            out_sel[i] <= ofr_src_e'(hwdata[i*`OFR_SEL_STRIDE +: `OFR_SEL_W]);
        end
      end
      if (wr_aux)
      begin
        for (int i = 0; i < 4; i++)
        begin
          if (sel_ok(hwdata[i*`OFR_SEL_STRIDE +: `OFR_SEL_W], 1'b0, 1'b1, variant.logic_op_used))
            out_sel[i+2] <= ofr_src_e'(hwdata[i*`OFR_SEL_STRIDE +: `OFR_SEL_W]);
        end
      end
      if (hc_rise)
      begin
        if (variant.two_ctrl_outputs)
        begin
          if (out_sel[1] == SRC_NONE)
            out_sel[1] <= SRC_COOL;
        end
        else if (variant.aux_two_only)
          out_sel[3] <= SRC_COOL;
        else
          out_sel[5] <= SRC_COOL;
      end
    end
  end

  // Combined-alarm source mask, any 8-bit value accepted
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      combined_alarm_source_mask <= `OFR_RST_MASK;
    else if (wr_mask)
      combined_alarm_source_mask <= hwdata[7:0];
  end

  // Control configuration; a reserved soak code keeps the old unit
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      heat_cool <= 1'b0;
      pattern_on <= 1'b0;
      soak_unit <= `OFR_RST_SOAK;
      alarm_target <= 1'b0;
    end
    else if (wr_cfg)
    begin
      heat_cool <= hwdata[`OFR_CFG_HEAT_COOL];
      pattern_on <= hwdata[`OFR_CFG_PATTERN_ON];
      if (new_soak != 2'h3)
        soak_unit <= new_soak;
      alarm_target <= hwdata[`OFR_CFG_ALARM_TARGET];
    end
  end

  // Weighted OR; the spare weight 128 has no source behind it
  assign combined_now = |(combined_alarm_source_mask[6:0] &
                          {funcs.input_error, funcs.heater_short_alarm, funcs.heater_burnout_alarm,
                           funcs.alarm});

  // Registered copies of the control-side results
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      combined_alarm <= 1'b0;
      soak_time_unit <= `OFR_RST_SOAK;
      soak_unit_valid <= 1'b0;
      alarm_ref_target <= 1'b0;
    end
    else
    begin
      combined_alarm <= combined_now;
      soak_time_unit <= soak_unit;
      soak_unit_valid <= pattern_on;
      alarm_ref_target <= alarm_target;
    end
  end

  // Terminals that are not fitted never drive
  assign out_present = {variant.aux_present, variant.two_ctrl_outputs, 1'b1};

  // One source multiplexer per output terminal
  genvar g;
  generate
    for (g = 0; g < 6; g++)
    begin : g_out
      ofr_source_mux u_mux (
        .mclk(mclk),
        .rst_n(rst_n),
        .sel(out_sel[g]),
        .funcs(funcs),
        .combined(combined_now),
        .heat_cool(heat_cool),
        .pattern_on(pattern_on),
        .present(out_present[g]),
        .drive(out_drive[g])
      );
    end
  endgenerate

  assign ctrl_out = out_drive[1:0];
  assign aux_out = out_drive[5:2];

  // Read mux, evaluated in the address phase and held in a flop
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    case (haddr[7:0])
      `OFR_ADDR_CTRL_SEL: next_rdata = {19'h0, 5'(out_sel[1]),
                                        3'h0, 5'(out_sel[0])};
      `OFR_ADDR_AUX_SEL: next_rdata = {3'h0, 5'(out_sel[5]), 3'h0, 5'(out_sel[4]),
                                       3'h0, 5'(out_sel[3]), 3'h0, 5'(out_sel[2])};
      `OFR_ADDR_MASK: next_rdata = {24'h0, combined_alarm_source_mask};
      `OFR_ADDR_CONFIG: next_rdata = {27'h0, alarm_target, soak_unit, pattern_on, heat_cool};
      `OFR_ADDR_STATUS: next_rdata = {24'h0, pattern_on, combined_alarm, out_drive};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      hrdata <= 32'h0000_0000;
    else if (hready && hsel && htrans[1] && !hwrite)
      hrdata <= next_rdata;
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  property p_heat_follow;
    (out_sel[0] == SRC_HEAT) |=> (ctrl_out[0] == $past(funcs.heat_mv));
  endproperty
  a_heat_follow: assert property (p_heat_follow) else $error("heat source not followed");

  property p_reset_defaults;
    $rose(rst_n) |-> (out_sel[0] == SRC_HEAT && out_sel[1] == SRC_NONE && out_sel[3] == SRC_AL2
                      && out_sel[4] == SRC_AL3 && out_sel[5] == SRC_AL4);
  endproperty
  a_reset_defaults: assert property (p_reset_defaults) else $error("bad selector defaults");

  property p_cool_std;
    (out_sel[1] == SRC_COOL && !heat_cool) |=> !ctrl_out[1];
  endproperty
  a_cool_std: assert property (p_cool_std) else $error("cooling driven under standard");

  property p_hc_auto;
    (hc_rise && variant.two_ctrl_outputs && out_sel[1] == SRC_NONE) |=> (out_sel[1] == SRC_COOL);
  endproperty
  a_hc_auto: assert property (p_hc_auto) else $error("output two not switched to cooling");

  property p_pend_off;
    (out_sel[2] == SRC_PEND && !pattern_on) |=> !aux_out[0];
  endproperty
  a_pend_off: assert property (p_pend_off) else $error("program end active with pattern off");

  property p_type_refuse;
    (wr_ctrl && !variant.ctrl_switching[0] && hwdata[4:0] >= 5'(SRC_AL1)) |=> $stable(out_sel[0]);
  endproperty
  a_type_refuse: assert property (p_type_refuse) else $error("status choice on linear output");

  property p_wf_hidden;
    (wr_aux && !variant.logic_op_used && hwdata[4:0] >= 5'(SRC_WF1)) |=> $stable(out_sel[2]);
  endproperty
  a_wf_hidden: assert property (p_wf_hidden) else $error("work flag accepted while unused");

  property p_single_route;
    (hc_rise && !variant.two_ctrl_outputs && !variant.aux_two_only) |=> (out_sel[5] == SRC_COOL);
  endproperty
  a_single_route: assert property (p_single_route) else $error("cooling not routed to aux four");

  property p_comb_weight;
    (funcs.heater_short_alarm && combined_alarm_source_mask[5]) |=> combined_alarm;
  endproperty
  a_comb_weight: assert property (p_comb_weight) else $error("short alarm weight lost");

  property p_mask_write;
    wr_mask |=> (combined_alarm_source_mask == $past(hwdata[7:0]));
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask write lost");

  property p_soak_keep;
    (wr_cfg && new_soak == 2'h3) |=> $stable(soak_unit);
  endproperty
  a_soak_keep: assert property (p_soak_keep) else $error("reserved soak unit stored");

  property p_disabled_idle;
    (out_sel[3] == SRC_NONE) |=> !aux_out[1];
  endproperty
  a_disabled_idle: assert property (p_disabled_idle) else $error("disabled output active");

  c_hc_switch: cover property (hc_rise ##1 out_sel[1] == SRC_COOL);
  c_comb_out: cover property (out_sel[0] == SRC_COMB ##1 ctrl_out[0]);
  c_wf_out: cover property (out_sel[2] == SRC_WF1 ##1 aux_out[0]);
  c_read: cover property (dp_valid && !dp_write && dp_addr == `OFR_ADDR_STATUS);
endmodule
`default_nettype wire

// File: tb/ofr_drive_model.sv
`timescale 1ns/100ps
`default_nettype none
module ofr_drive_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [5:0] drive,
  output var logic [5:0] energised
);
  // Contacts follow the drive one clock late, as an armature needs time to pull in
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      energised <= 6'h00;
    else
      energised <= drive;
  end
endmodule
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "ofr_params.svh"
module testbench
  import ofr_pkg::*;
;
  localparam ofr_variant_s BASE_STRAPS = '{1'b1, 2'b11, 4'hf, 1'b0, 1'b0, 1'b1};
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  ofr_func_s funcs = '0;
  ofr_variant_s variant_pins = BASE_STRAPS;
  logic [1:0] ctrl_out;
  logic [3:0] aux_out;
  logic combined_alarm;
  logic [1:0] soak_time_unit;
  logic soak_unit_valid;
  logic alarm_ref_target;
  logic [5:0] energised;
  int fail_count = 0;
  int comparisons = 0;

  // Single slave, so its ready is the bus ready
  ofr_router i_ofr_router (.mclk(mclk), .rst_n(rst_n), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .funcs(funcs), .variant_pins(variant_pins), .ctrl_out(ctrl_out),
    .aux_out(aux_out), .combined_alarm(combined_alarm), .soak_time_unit(soak_time_unit),
    .soak_unit_valid(soak_unit_valid), .alarm_ref_target(alarm_ref_target));

  ofr_drive_model i_ofr_drive_model (.mclk(mclk), .rst_n(rst_n), .drive({aux_out, ctrl_out}),
    .energised(energised));

  // Free-running 40 MHz clock
  initial
  begin
    forever #12.5 mclk = ~mclk;
  end

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check_eq(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // Bounded wait for ready; a stuck slave ends the run instead of hanging it
  task automatic wait_ready();
    int n;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      fail_count++;
      $display("Error at %0t: bus wait ran out", $time);
      give_verdict();
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge mclk);
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask

  // Outputs lag a register write by one cycle and a function input by one
  task automatic settle();
    repeat (3) @(posedge mclk);
    #1;
  endtask

  // Function levels change by NBA on an edge; outputs are judged once settled
  task automatic set_funcs(input ofr_func_s f);
    @(posedge mclk);
    funcs <= f;
    settle();
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
    settle();
  endtask

  task automatic rd_check(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    check_eq(x, exp);
    check_eq(32'(hresp), 32'h0);
  endtask

  task automatic do_reset(input ofr_variant_s v);
    @(posedge mclk);
    variant_pins <= v;
    rst_n <= 1'b0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
  endtask

  // The single internal function that a selector code should carry
  function automatic ofr_func_s one_src(input int k);
    ofr_func_s f;
    f = '0;
    case (k)
      1: f.heat_mv = 1'b1;
      2: f.cool_mv = 1'b1;
      3, 4, 5, 6: f.alarm[k-3] = 1'b1;
      7: f.heater_alarm = 1'b1;
      8: f.heater_burnout_alarm = 1'b1;
      9: f.heater_short_alarm = 1'b1;
      10: f.input_error = 1'b1;
      12: f.program_end = 1'b1;
      13: f.run_state = 1'b1;
      14: f.alarm[0] = 1'b1;
      default: if (k >= 15) f.logic_work_flag[k-15] = 1'b1;
    endcase
    return f;
  endfunction

  task automatic check_defaults();
    rd_check(`OFR_ADDR_CTRL_SEL, 32'h0000_0001);
    rd_check(`OFR_ADDR_AUX_SEL, 32'h0605_0403);
    rd_check(`OFR_ADDR_MASK, 32'h0000_0031);
    rd_check(`OFR_ADDR_CONFIG, 32'h0000_0004);
    check_eq(32'(soak_time_unit), 32'h1);
    check_eq(32'(alarm_ref_target), 32'h0);
  endtask

  // Every code on aux one and control one, its own source alone, then all others except for code 14
  task automatic check_routing();
    ofr_func_s f;
    logic exp;
    wr_reg(`OFR_ADDR_CONFIG, 32'h0000_0007);
    for (int k = 0; k <= 22; k++)
    begin
      f = one_src(k);
      exp = (k != 0 && k != 11);
      wr_reg(`OFR_ADDR_AUX_SEL, {24'h060504, 8'(k)});
      wr_reg(`OFR_ADDR_CTRL_SEL, {24'h000002, 8'(k)});
      set_funcs(f);
      check_eq(32'(aux_out), 32'({k == 6, k == 5, k == 4, exp}));
      check_eq(32'(ctrl_out), 32'({k == 2, exp}));
      check_eq(32'(energised[2]), 32'(exp));
      if (k != 14)
      begin
        set_funcs(~f);
        check_eq(32'(aux_out), 32'({k != 6, k != 5, k != 4, 1'b0}));
      end
    end
  endtask

  task automatic check_gating();
    wr_reg(`OFR_ADDR_CONFIG, 32'h0000_0004);
    set_funcs('1);
    wr_reg(`OFR_ADDR_AUX_SEL, 32'h0605_0002);
    check_eq(32'(aux_out[0]), 32'h0);
    check_eq(32'(aux_out[1]), 32'h0);
    wr_reg(`OFR_ADDR_AUX_SEL, 32'h0605_040c);
    check_eq(32'(aux_out[0]), 32'h0);
    check_eq(32'(soak_unit_valid), 32'h0);
    wr_reg(`OFR_ADDR_CONFIG, 32'h0000_0006);
    check_eq(32'(aux_out[0]), 32'h1);
    rd_check(`OFR_ADDR_STATUS, 32'h0000_00fd);
  endtask

  // One weight at a time, then the spare weight alone, then all weights
  task automatic check_mask();
    ofr_func_s f;
    for (int i = 0; i <= 6; i++)
    begin
      f = one_src(i < 4 ? i + 3 : i + 4);
      wr_reg(`OFR_ADDR_MASK, 32'h1 << i);
      set_funcs(f);
      check_eq(32'(combined_alarm), 32'h1);
      set_funcs(~f);
      check_eq(32'(combined_alarm), 32'h0);
    end
    wr_reg(`OFR_ADDR_MASK, 32'h0000_0080);
    set_funcs('1);
    check_eq(32'(combined_alarm), 32'h0);
    wr_reg(`OFR_ADDR_MASK, 32'h0000_00ff);
    rd_check(`OFR_ADDR_MASK, 32'h0000_00ff);
    check_eq(32'(combined_alarm), 32'h1);
  endtask

  task automatic check_config();
    for (int u = 0; u <= 2; u++)
    begin
      wr_reg(`OFR_ADDR_CONFIG, 32'((u << 2) | 2 | ((u & 1) << 4)));
      check_eq(32'(soak_time_unit), 32'(u));
      check_eq(32'(alarm_ref_target), 32'(u & 1));
    end
    wr_reg(`OFR_ADDR_CONFIG, 32'h0000_000e);
    rd_check(`OFR_ADDR_CONFIG, 32'h0000_000a);
    wr_reg(8'h40, 32'hffff_ffff);
    rd_check(8'h40, 32'h0);
  endtask

  // Strap variants: heater detection, switching type, logic use, single control output
  task automatic check_variants();
    do_reset('{1'b0, 2'b00, 4'hf, 1'b1, 1'b1, 1'b0});
    rd_check(`OFR_ADDR_AUX_SEL, 32'h0605_0407);
    wr_reg(`OFR_ADDR_CTRL_SEL, 32'h0000_0003);
    rd_check(`OFR_ADDR_CTRL_SEL, 32'h0000_0001);
    wr_reg(`OFR_ADDR_AUX_SEL, 32'h0605_040f);
    rd_check(`OFR_ADDR_AUX_SEL, 32'h0605_0407);
    wr_reg(`OFR_ADDR_CONFIG, 32'h0000_0005);
    rd_check(`OFR_ADDR_AUX_SEL, 32'h0605_0207);
    do_reset('{1'b0, 2'b11, 4'hf, 1'b0, 1'b0, 1'b1});
    wr_reg(`OFR_ADDR_CONFIG, 32'h0000_0005);
    rd_check(`OFR_ADDR_AUX_SEL, 32'h0205_0403);
    do_reset(BASE_STRAPS);
    wr_reg(`OFR_ADDR_CONFIG, 32'h0000_0005);
    rd_check(`OFR_ADDR_CTRL_SEL, 32'h0000_0201);
  endtask

  initial
  begin
    do_reset(BASE_STRAPS);
    check_defaults();
    check_routing();
    check_gating();
    check_mask();
    check_config();
    check_variants();
    give_verdict();
  end
endmodule
`default_nettype wire
